//--- design/rst_ctl_pkg.sv
package rst_ctl_pkg;

	// =====================================================================
	// async input bundle layout
	localparam int PORT_COUNT = 8;
	localparam int ASYNC_W = PORT_COUNT + 5;
	localparam int IN_DBG = 0;
	localparam int IN_LVD = 1;
	localparam int IN_DROOP = 2;
	localparam int IN_POR = 3;
	localparam int IN_RPIN = 4;
	localparam int IN_PORT0 = 5;
	localparam logic [ASYNC_W-1:0] ASYNC_IDLE = 13'h0011;

	// =====================================================================
	// cause register layout
	localparam int CAUSE_W = 8;
	localparam int RESERVED_W = 3;

	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int IPO_STARTUP_NS = 4000;
	localparam int IPO_STARTUP_CYCLES =
		(IPO_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_SHORT_CYCLES = 66;
	localparam int HOLD_LONG_CYCLES = 5000;
	localparam int HOLD_W = 14;
	localparam logic [HOLD_W-1:0] LOAD_SHORT =
		HOLD_W'(HOLD_SHORT_CYCLES + IPO_STARTUP_CYCLES);
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] EXT_QUAL_CYCLES = 4'h3;
	localparam logic [CNT_W-1:0] STOP_FILTER_CYCLES = 4'h8;
	localparam logic [CNT_W-1:0] SETTLE_CYCLES = 4'h4;
	localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;

	// =====================================================================
	// reset vector location
	localparam logic [15:0] VECTOR_ADDR_HI = 16'h0002;
	localparam logic [15:0] VECTOR_ADDR_LO = 16'h0003;

	// =====================================================================
	// types
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_SYSRST = 4'b0010,
		ST_PINWAIT = 4'b0100,
		ST_SMR = 4'b1000
	} state_type;

	typedef struct packed {
		logic por;
		logic stop;
		logic wdt;
		logic external_reset_flag;
	} cause_type;

	localparam cause_type CAUSE_NONE = 4'h0;
	localparam cause_type CAUSE_POR = 4'h8;
	localparam cause_type CAUSE_SMR = 4'h4;
	localparam cause_type CAUSE_WDT = 4'h2;
	localparam cause_type CAUSE_EXT = 4'h1;
	localparam cause_type CAUSE_SMR_WDT = 4'h6;

	typedef struct packed {
		state_type state;
		logic [ASYNC_W-1:0] s1;
		logic [ASYNC_W-1:0] s2;
		logic [ASYNC_W-1:0] s3;
		logic [ASYNC_W-1:0] f;
		logic [CNT_W-1:0] ext_cnt;
		logic [CNT_W-1:0] settle_cnt;
		logic [HOLD_W-1:0] hold_cnt;
		cause_type pend;
		cause_type cause;
		logic int_after;
		logic [PORT_COUNT-1:0] port_data;
		logic cpu_rst;
		logic periph_rst;
		logic pin_oe;
		logic lvd_flag;
		logic lvd_int;
		logic wdt_int;
		logic dbg_clr;
		logic ctl_restore;
		logic ipo_sel;
		logic vec_fetch;
		logic port_int;
		logic [15:0] vec_hi;
		logic [15:0] vec_lo;
	} ctl_type;

	localparam ctl_type CTL_RESET = '{
		state: ST_SYSRST,
		s1: ASYNC_IDLE,
		s2: ASYNC_IDLE,
		s3: ASYNC_IDLE,
		f: ASYNC_IDLE,
		ext_cnt: '0,
		settle_cnt: '0,
		hold_cnt: LOAD_SHORT,
		pend: CAUSE_POR,
		cause: CAUSE_NONE,
		int_after: 1'b0,
		port_data: '0,
		cpu_rst: 1'b1,
		periph_rst: 1'b1,
		pin_oe: 1'b1,
		lvd_flag: 1'b0,
		lvd_int: 1'b0,
		wdt_int: 1'b0,
		dbg_clr: 1'b0,
		ctl_restore: 1'b0,
		ipo_sel: 1'b0,
		vec_fetch: 1'b0,
		port_int: 1'b0,
		vec_hi: VECTOR_ADDR_HI,
		vec_lo: VECTOR_ADDR_LO
	};

endpackage

//--- design/reset_and_stop_recovery_control.sv
`timescale 1ns/1ps
module reset_and_stop_recovery_control #(
	parameter int HOLD_LONG = rst_ctl_pkg::HOLD_LONG_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic SUPPLY_BELOW_POR,
	input wire logic DROOP_DETECT,
	input wire logic LOW_SUPPLY,
	input wire logic DROOP_IN_STOP_OPT,
	input wire logic WATCHDOG_RESET_SELECT,
	input wire logic XTAL_ENABLE_OPT,
	input wire logic WDT_TIMEOUT,
	input wire logic DEBUG_RST_REQ,
	input wire logic DEBUG_PIN_IN,
	input wire logic RESET_PIN_IN,
	input wire logic STOP_MODE,
	input wire logic [rst_ctl_pkg::PORT_COUNT-1:0] PORT_PINS,
	input wire logic [rst_ctl_pkg::PORT_COUNT-1:0] PORT_RECOVERY_EN,
	input wire logic CAUSE_READ,
	input wire logic LVD_INT_EN,
	output logic CPU_RESET,
	output logic PERIPH_RESET,
	output logic RESET_PIN_OUT,
	output logic RESET_PIN_OE,
	output logic [rst_ctl_pkg::CAUSE_W-1:0] RESET_CAUSE,
	output logic LOW_SUPPLY_FLAG,
	output logic LVD_INT,
	output logic WDT_INT,
	output logic DEBUG_RST_CLEAR,
	output logic CTL_RESTORE,
	output logic IPO_SELECT,
	output logic VECTOR_FETCH,
	output logic [15:0] VECTOR_HI_ADDR,
	output logic [15:0] VECTOR_LO_ADDR,
	output logic [rst_ctl_pkg::PORT_COUNT-1:0] PORT_INPUT_DATA,
	output logic PORT_CHANGE_INT
);
	import rst_ctl_pkg::*;

	// =====================================================================
	// hold lengths
	localparam logic [HOLD_W-1:0] LOAD_LONG =
		HOLD_W'(HOLD_LONG + IPO_STARTUP_CYCLES);

	// =====================================================================
	// synchroniser filter: take stage three only when stages two and three
	// agree, otherwise keep the last accepted level
	function automatic logic [ASYNC_W-1:0] settle(
		input logic [ASYNC_W-1:0] s2,
		input logic [ASYNC_W-1:0] s3,
		input logic [ASYNC_W-1:0] prev
	);
		logic [ASYNC_W-1:0] diff;
		diff = s2 ^ s3;
		settle = (~diff & s3) | (diff & prev);
	endfunction

	ctl_type r;
	ctl_type n;
	logic [ASYNC_W-1:0] async_in;
	logic [HOLD_W-1:0] hold_load;
	logic [PORT_COUNT-1:0] port_now;
	logic [PORT_COUNT-1:0] port_moved;
	logic [CNT_W-1:0] ext_need;
	logic droop_on;
	logic por_low;
	logic droop;
	logic pin_low;
	logic ext_qual;
	logic dbg_low;
	logic go_sys;
	logic go_smr;
	logic smr_wdt;
	cause_type sys_cause;
	cause_type smr_cause;

	assign async_in = {PORT_PINS, RESET_PIN_IN, SUPPLY_BELOW_POR,
		DROOP_DETECT, LOW_SUPPLY, DEBUG_PIN_IN};

	// =====================================================================
	// next state
	always_comb begin
		n = r;
		n.dbg_clr = 1'b0;
		n.ctl_restore = 1'b0;
		n.ipo_sel = 1'b0;
		n.vec_fetch = 1'b0;
		n.port_int = 1'b0;
		n.wdt_int = 1'b0;
		go_sys = 1'b0;
		go_smr = 1'b0;
		smr_wdt = 1'b0;
		sys_cause = CAUSE_NONE;
		smr_cause = CAUSE_NONE;

		// three-stage capture of pins and analog comparators
		n.s1 = async_in;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.f = settle(r.s2, r.s3, r.f);

		droop_on = ~STOP_MODE | DROOP_IN_STOP_OPT;
		por_low = r.f[IN_POR];
		droop = r.f[IN_DROOP] & droop_on;
		n.lvd_flag = r.f[IN_LVD] & droop_on;
		n.lvd_int = n.lvd_flag & LVD_INT_EN;

		hold_load = XTAL_ENABLE_OPT ? LOAD_LONG : LOAD_SHORT;
		port_now = r.f[IN_PORT0 +: PORT_COUNT];
		port_moved = (port_now ^ r.port_data) & PORT_RECOVERY_EN;

		// low time of the reset pin, longer filter while stopped
		pin_low = ~r.f[IN_RPIN];
		ext_need = STOP_MODE ? STOP_FILTER_CYCLES : EXT_QUAL_CYCLES;
		ext_qual = pin_low && (r.ext_cnt >= ext_need - 4'h1);
		if (!pin_low)
			n.ext_cnt = '0;
		else if (r.ext_cnt != CNT_MAX)
			n.ext_cnt = r.ext_cnt + 4'h1;
		dbg_low = ~r.f[IN_DBG] & STOP_MODE;

		// reading clears the cause flags; a load below wins
		if (CAUSE_READ)
			n.cause = CAUSE_NONE;

		unique case (r.state)
			ST_RUN: begin
				if (!STOP_MODE)
					n.port_data = port_now;
				if (por_low || droop) begin
					go_sys = 1'b1;
					sys_cause = CAUSE_POR;
				end else if (ext_qual) begin
					go_sys = 1'b1;
					sys_cause = CAUSE_EXT;
				end else if (dbg_low) begin
					go_sys = 1'b1;
					sys_cause = CAUSE_POR;
				end else if (DEBUG_RST_REQ) begin
					go_sys = 1'b1;
					sys_cause = CAUSE_POR;
				end else if (WDT_TIMEOUT) begin
					if (STOP_MODE) begin
						go_smr = 1'b1;
						smr_wdt = 1'b1;
						smr_cause = CAUSE_SMR_WDT;
					end else if (WATCHDOG_RESET_SELECT) begin
						go_sys = 1'b1;
						sys_cause = CAUSE_WDT;
					end else begin
						n.wdt_int = 1'b1;
					end
				end else if (STOP_MODE && (|port_moved)) begin
					go_smr = 1'b1;
					smr_cause = CAUSE_SMR;
				end
			end
			ST_SYSRST: begin
				n.ext_cnt = '0;
				if (por_low || droop) begin
					n.hold_cnt = hold_load;
					n.pend = CAUSE_POR;
				end else if (r.hold_cnt <= 14'h0001) begin
					// let go of the pin, then watch it from outside
					n.pin_oe = 1'b0;
					n.settle_cnt = '0;
					n.state = ST_PINWAIT;
				end else begin
					n.hold_cnt = r.hold_cnt - 14'h0001;
				end
			end
			ST_PINWAIT: begin
				n.ext_cnt = '0;
				if (por_low || droop) begin
					go_sys = 1'b1;
					sys_cause = CAUSE_POR;
				end else if (r.settle_cnt < SETTLE_CYCLES - 4'h1) begin
					n.settle_cnt = r.settle_cnt + 4'h1;
				end else if (r.f[IN_RPIN]) begin
					// leave on the first edge seeing the pin high
					n.state = ST_RUN;
					n.cpu_rst = 1'b0;
					n.periph_rst = 1'b0;
					n.cause = r.pend;
					n.vec_fetch = 1'b1;
					n.ipo_sel = 1'b1;
					n.port_data = port_now;
				end
			end
			ST_SMR: begin
				if (por_low || droop) begin
					go_sys = 1'b1;
					sys_cause = CAUSE_POR;
				end else if (ext_qual) begin
					go_sys = 1'b1;
					sys_cause = CAUSE_EXT;
				end else if (dbg_low) begin
					go_sys = 1'b1;
					sys_cause = CAUSE_POR;
				end else if (r.hold_cnt <= 14'h0001) begin
					n.state = ST_RUN;
					n.cpu_rst = 1'b0;
					n.cause = r.pend;
					n.vec_fetch = 1'b1;
					n.ipo_sel = 1'b1;
					// only levels still present now reach the data
					n.port_data = port_now;
					n.port_int = |port_moved;
					n.wdt_int = r.int_after;
				end else begin
					n.hold_cnt = r.hold_cnt - 14'h0001;
				end
			end
		endcase

		if (go_sys) begin
			n.state = ST_SYSRST;
			n.hold_cnt = hold_load;
			n.pend = sys_cause;
			n.cpu_rst = 1'b1;
			n.periph_rst = 1'b1;
			n.pin_oe = 1'b1;
			n.dbg_clr = DEBUG_RST_REQ;
			n.int_after = 1'b0;
			n.ext_cnt = '0;
		end else if (go_smr) begin
			n.state = ST_SMR;
			n.hold_cnt = hold_load;
			n.pend = smr_cause;
			n.cpu_rst = 1'b1;
			// peripherals keep state; only the two control registers reload
			n.ctl_restore = 1'b1;
			n.int_after = smr_wdt & ~WATCHDOG_RESET_SELECT;
		end
	end

	// =====================================================================
	// state register
	always_ff @(posedge REF_CLK) begin
		if (SRST)
			r <= CTL_RESET;
		else
			r <= n;
	end

	// =====================================================================
	// outputs
	assign CPU_RESET = r.cpu_rst;
	assign PERIPH_RESET = r.periph_rst;
	assign RESET_PIN_OUT = 1'b0;
	assign RESET_PIN_OE = r.pin_oe;
	assign RESET_CAUSE = {r.cause, {RESERVED_W{1'b0}}, r.lvd_flag};
	assign LOW_SUPPLY_FLAG = r.lvd_flag;
	assign LVD_INT = r.lvd_int;
	assign WDT_INT = r.wdt_int;
	assign DEBUG_RST_CLEAR = r.dbg_clr;
	assign CTL_RESTORE = r.ctl_restore;
	assign IPO_SELECT = r.ipo_sel;
	assign VECTOR_FETCH = r.vec_fetch;
	assign VECTOR_HI_ADDR = r.vec_hi;
	assign VECTOR_LO_ADDR = r.vec_lo;
	assign PORT_INPUT_DATA = r.port_data;
	assign PORT_CHANGE_INT = r.port_int;

endmodule

//--- verif/reset_line_model.sv
`timescale 1ns/1ps
// ====
// reset wire: pull-up, pulled low by device or far side
module reset_line_model (
	input wire logic oe,
	input wire logic ext_low,
	output logic level
);
	assign level = !(oe || ext_low);
endmodule

//--- verif/rst_ctl_chk.sv
`timescale 1ns/1ps
module rst_ctl_chk
	import rst_ctl_pkg::*;
	#(parameter int HOLD_LONG = 5000) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic DROOP_DETECT,
	input wire logic WATCHDOG_RESET_SELECT,
	input wire logic WDT_TIMEOUT,
	input wire logic STOP_MODE,
	input wire logic DROOP_IN_STOP_OPT,
	input wire logic XTAL_ENABLE_OPT,
	input wire logic LVD_INT_EN,
	input wire logic CPU_RESET,
	input wire logic PERIPH_RESET,
	input wire logic RESET_PIN_OUT,
	input wire logic RESET_PIN_OE,
	input wire logic [rst_ctl_pkg::CAUSE_W-1:0] RESET_CAUSE,
	input wire logic LOW_SUPPLY_FLAG,
	input wire logic LVD_INT,
	input wire logic WDT_INT,
	input wire logic CTL_RESTORE,
	input wire logic IPO_SELECT,
	input wire logic VECTOR_FETCH,
	input wire logic [15:0] VECTOR_HI_ADDR,
	input wire logic [15:0] VECTOR_LO_ADDR
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	logic [13:0] oe_cnt;
	logic run_wd;
	localparam logic [13:0] OE_SHORT =
		14'(HOLD_SHORT_CYCLES + IPO_STARTUP_CYCLES);
	localparam logic [13:0] OE_LONG = 14'(HOLD_LONG + IPO_STARTUP_CYCLES);
	// ====
	// cycles the reset pin has been pulled low
	always_ff @(posedge REF_CLK) begin
		if (SRST || !RESET_PIN_OE) begin
			oe_cnt <= '0;
		end else begin
			oe_cnt <= oe_cnt + 14'h1;
		end
	end
	assign run_wd = WDT_TIMEOUT && !CPU_RESET && !STOP_MODE;
	a_pin_drive: assert property (RESET_PIN_OUT == 1'b0)
		else $error("reset pin value not low");
	a_oe_reset: assert property (RESET_PIN_OE |-> CPU_RESET && PERIPH_RESET)
		else $error("pin pulled outside system reset");
	a_oe_hold: assert property ($fell(RESET_PIN_OE) |->
		oe_cnt >= (XTAL_ENABLE_OPT ? OE_LONG : OE_SHORT))
		else $error("reset pin released early");
	a_droop_reset: assert property (DROOP_DETECT
		&& (!STOP_MODE || DROOP_IN_STOP_OPT) |-> ##[1:8] CPU_RESET)
		else $error("droop did not hold reset");
	a_wdt_reset: assert property (run_wd && WATCHDOG_RESET_SELECT
		|-> ##[1:2] PERIPH_RESET)
		else $error("watchdog reset missing");
	a_wdt_irq: assert property (run_wd && !WATCHDOG_RESET_SELECT
		|-> ##[1:2] (WDT_INT && !CPU_RESET))
		else $error("watchdog interrupt missing");
	a_exit_vector: assert property ($fell(CPU_RESET) |-> VECTOR_FETCH && IPO_SELECT)
		else $error("no vector fetch at exit");
	a_vector_addr: assert property (VECTOR_HI_ADDR == 16'h0002 && VECTOR_LO_ADDR == 16'h0003)
		else $error("vector address wrong");
	a_low_flag: assert property (RESET_CAUSE[0] == LOW_SUPPLY_FLAG)
		else $error("low supply bit mismatch");
	a_lvd_irq: assert property ((LOW_SUPPLY_FLAG && LVD_INT_EN)[*2] |-> LVD_INT)
		else $error("low supply interrupt missing");
	a_lvd_in_stop: assert property (STOP_MODE && !DROOP_IN_STOP_OPT
		|=> !LOW_SUPPLY_FLAG)
		else $error("low supply flag live with detector off");
	a_smr_restore: assert property ($rose(CPU_RESET) && !PERIPH_RESET
		|-> CTL_RESTORE)
		else $error("control reload missing at recovery");
	cover property (WDT_INT);
	cover property ($rose(RESET_PIN_OE));
	cover property ($fell(CPU_RESET) ##[1:4] RESET_CAUSE[6]);
endmodule
bind reset_and_stop_recovery_control rst_ctl_chk #(.HOLD_LONG(HOLD_LONG))
	rst_ctl_chk_inst (.REF_CLK(REF_CLK), .SRST(SRST),
	.DROOP_DETECT(DROOP_DETECT), .WATCHDOG_RESET_SELECT(WATCHDOG_RESET_SELECT),
	.WDT_TIMEOUT(WDT_TIMEOUT), .STOP_MODE(STOP_MODE),
	.LVD_INT_EN(LVD_INT_EN), .CPU_RESET(CPU_RESET),
	.PERIPH_RESET(PERIPH_RESET), .RESET_PIN_OUT(RESET_PIN_OUT),
	.RESET_PIN_OE(RESET_PIN_OE), .RESET_CAUSE(RESET_CAUSE),
	.LOW_SUPPLY_FLAG(LOW_SUPPLY_FLAG), .LVD_INT(LVD_INT),
	.WDT_INT(WDT_INT), .IPO_SELECT(IPO_SELECT),
	.CTL_RESTORE(CTL_RESTORE), .DROOP_IN_STOP_OPT(DROOP_IN_STOP_OPT),
	.XTAL_ENABLE_OPT(XTAL_ENABLE_OPT),
	.VECTOR_FETCH(VECTOR_FETCH), .VECTOR_HI_ADDR(VECTOR_HI_ADDR),
	.VECTOR_LO_ADDR(VECTOR_LO_ADDR));

//--- verif/reset_and_stop_recovery_control_tb_top.sv
`timescale 1ns/1ps
module reset_and_stop_recovery_control_tb_top;
	import rst_ctl_pkg::*;
	logic clk, srst, below_por, droop, low_sup, wdt, wdt_sel, dbg_req;
	logic dbg_pin, ext_low, stop, rd, lvd_en, cpu_rst, per_rst, pin_oe;
	logic pin_lvl, lvd_int, wdt_int, dbg_clr, xtal, vbo_stop, port_int;
	logic [PORT_COUNT-1:0] pins, pins_en, port_data;
	logic [CAUSE_W-1:0] cause;
	int n_mismatch, checks, cyc_n;
	localparam int HOLD_LONG_TB = 50;
	reset_and_stop_recovery_control #(.HOLD_LONG(HOLD_LONG_TB))
		reset_and_stop_recovery_control_inst (
		.REF_CLK(clk), .SRST(srst), .SUPPLY_BELOW_POR(below_por),
		.DROOP_DETECT(droop), .LOW_SUPPLY(low_sup),
		.DROOP_IN_STOP_OPT(vbo_stop), .WATCHDOG_RESET_SELECT(wdt_sel),
		.XTAL_ENABLE_OPT(xtal), .WDT_TIMEOUT(wdt), .DEBUG_RST_REQ(dbg_req),
		.DEBUG_PIN_IN(dbg_pin), .RESET_PIN_IN(pin_lvl), .STOP_MODE(stop),
		.PORT_PINS(pins), .PORT_RECOVERY_EN(pins_en), .CAUSE_READ(rd),
		.LVD_INT_EN(lvd_en), .CPU_RESET(cpu_rst), .PERIPH_RESET(per_rst),
		.RESET_PIN_OUT(), .RESET_PIN_OE(pin_oe), .RESET_CAUSE(cause),
		.LOW_SUPPLY_FLAG(), .LVD_INT(lvd_int), .WDT_INT(wdt_int),
		.DEBUG_RST_CLEAR(dbg_clr), .CTL_RESTORE(), .IPO_SELECT(),
		.VECTOR_FETCH(), .VECTOR_HI_ADDR(), .VECTOR_LO_ADDR(),
		.PORT_INPUT_DATA(port_data), .PORT_CHANGE_INT(port_int));
	reset_line_model reset_line_model_inst (.oe(pin_oe),
		.ext_low(ext_low), .level(pin_lvl));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// ====
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wd();
		wdt = 1'b1;
		cyc(1);
		wdt = 1'b0;
	endtask
	// wait for reset entry, end stop, then wait for the exit
	task automatic wexit();
		int i;
		for (i = 0; i < 40 && cpu_rst !== 1'b1; i++) cyc(1);
		stop = 1'b0;
		dbg_pin = 1'b1;
		for (i = 0; i < 3000 && cpu_rst !== 1'b0; i++) cyc(1);
		chk(cpu_rst, 8'h0);
	endtask
	// wait for reset entry, then count the cycles the hold lasts
	task automatic hold_len(input bit oe);
		int n;
		int exp;
		exp = IPO_STARTUP_CYCLES + (xtal ? HOLD_LONG_TB : HOLD_SHORT_CYCLES);
		for (n = 0; n < 40 && cpu_rst !== 1'b1; n++) cyc(1);
		n = 0;
		while (n < 400 && (oe ? pin_oe : cpu_rst) === 1'b1) begin
			cyc(1);
			n++;
		end
		chk(8'(n), 8'(exp));
	endtask
	task automatic cause_is(input logic [3:0] exp);
		chk({4'h0, cause[7:4]}, {4'h0, exp});
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		cyc(1);
		chk({4'h0, cause[7:4]}, 8'h0);
	endtask
	task automatic end_of_test();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ====
	// tests
	initial begin
		{srst, below_por, droop, low_sup, wdt, wdt_sel, dbg_req} = '0;
		{ext_low, stop, rd, lvd_en, pins, pins_en, xtal} = '0;
		vbo_stop = 1'b1;
		{n_mismatch, checks, cyc_n} = '0;
		dbg_pin = 1'b1;
		srst = 1'b1;
		cyc(3);
		srst = 1'b0;
		wexit();
		cause_is(4'h8);
		for (int w = 2; w <= 4; w += 2) begin
			ext_low = 1'b1;
			cyc(w);
			ext_low = 1'b0;
			cyc(10);
			chk(cpu_rst, w == 4);
		end
		wexit();
		cause_is(4'h1);
		ext_low = 1'b1;
		cyc(300);
		chk(cpu_rst, 8'h1);
		chk(pin_oe, 8'h0);
		ext_low = 1'b0;
		cyc(8);
		chk(cpu_rst, 8'h0);
		cause_is(4'h1);
		wdt_sel = 1'b1;
		for (int x = 0; x < 2; x++) begin
			xtal = (x == 1);
			wd();
			hold_len(1'b1);
			wexit();
			cause_is(4'h2);
		end
		stop = 1'b1;
		pins_en = 8'h02;
		pins = 8'h02;
		hold_len(1'b0);
		chk(port_int, 8'h1);
		stop = 1'b0;
		xtal = 1'b0;
		cause_is(4'h4);
		wdt_sel = 1'b0;
		wd();
		chk(wdt_int, 8'h1);
		cyc(5);
		chk(cpu_rst, 8'h0);
		dbg_req = 1'b1;
		for (int i = 0; i < 10 && dbg_clr !== 1'b1; i++) cyc(1);
		chk(dbg_clr, 8'h1);
		dbg_req = 1'b0;
		chk(per_rst, 8'h1);
		wexit();
		cause_is(4'h8);
		{droop, below_por} = 2'b11;
		cyc(400);
		chk(cpu_rst, 8'h1);
		{droop, below_por} = 2'b00;
		wexit();
		cause_is(4'h8);
		pins_en = 8'h01;
		for (int v = 1; v >= 0; v--) begin
			stop = 1'b1;
			pins = 8'(v);
			cyc(12);
			chk(cpu_rst, 8'h1);
			chk(per_rst, 8'h0);
			wexit();
			chk(port_data, 8'(v));
			cause_is(4'h4);
		end
		stop = 1'b1;
		cyc(2);
		wd();
		wexit();
		chk(wdt_int, 8'h1);
		cause_is(4'h6);
		stop = 1'b1;
		ext_low = 1'b1;
		cyc(4);
		ext_low = 1'b0;
		cyc(12);
		chk(cpu_rst, 8'h0);
		dbg_pin = 1'b0;
		cyc(10);
		chk(per_rst, 8'h1);
		wexit();
		cause_is(4'h8);
		{lvd_en, low_sup} = 2'b11;
		cyc(8);
		cause_is(4'h0);
		chk(cause[0], 8'h1);
		chk(lvd_int, 8'h1);
		low_sup = 1'b0;
		cyc(8);
		chk(cause[0], 8'h0);
		{vbo_stop, stop, droop, low_sup} = 4'b0111;
		cyc(10);
		chk(cpu_rst, 8'h0);
		chk(cause[0], 8'h0);
		stop = 1'b0;
		cyc(4);
		chk(cpu_rst, 8'h1);
		chk(cause[0], 8'h1);
		{droop, low_sup} = 2'b00;
		wexit();
		cause_is(4'h8);
		end_of_test();
	end
endmodule
